// >>> core/alm_pkg.sv
// constants and types for the layer-4 access control entry matcher
// assumes one switch core clock; registers over axi4-lite, 32-bit words
// Behaviour
// (R1) Source port selector "any": source port ignored for the hit.
// (R2) Source selector "specific": hit needs source port equal to the 16-bit value.
// (R3) Source selector "range": hit needs source port within low and high bounds.
// (R4) Destination port selector "any": destination port ignored for the hit.
// (R5) Destination selector "specific": hit needs destination port equal to value.
// (R6) Destination selector "range": hit needs destination port within bounds.
// (R7) FIN selector 0 rejects TCP frames with FIN set; 1 requires FIN set.
// (R8) SYN selector 0 rejects TCP frames with SYN set; 1 requires SYN set.
// (R9) PSH selector 0 rejects TCP frames with PSH set; 1 requires PSH set.
// (R10) ACK selector 0 rejects TCP frames with ACK set; 1 requires ACK set.
// (R11) URG selector 0 rejects TCP frames with URG set; 1 requires URG set.
// (R12) Each flag selector has a don't-care setting ignoring that flag.
// (R13) Bound port admits frames only when source MAC and IP match the pair.
// (R14) Hit only when all port and flag conditions hold together.
package alm_pkg;
  localparam int ADDR_W = 6;
  localparam int NUM_PORTS = 8;
  localparam int NUM_FLAGS = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_SRC_LO = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_SRC_HI = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_DST_LO = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_DST_HI = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_BIND_EN = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_BIND_MAC_LO = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_BIND_MAC_HI = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_BIND_IP = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_HIT_CNT = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_DROP_CNT = 6'h2C;
  // ctrl fields
  localparam int CTRL_SRC_SEL_LSB = 0;
  localparam int CTRL_DST_SEL_LSB = 2;
  localparam int CTRL_FLAG_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // flag bit order in the frame flag vector: fin, syn, psh, ack, urg
  localparam int FLAG_FIN = 0;
  localparam int FLAG_SYN = 1;
  localparam int FLAG_PSH = 2;
  localparam int FLAG_ACK = 3;
  localparam int FLAG_URG = 4;
  typedef enum logic [1:0] {
    PSEL_ANY = 2'h0,
    PSEL_SPECIFIC = 2'h1,
    PSEL_RANGE = 2'h2
  } alm_psel_e;
  typedef enum logic [1:0] {
    FSEL_ZERO = 2'h0,
    FSEL_ONE = 2'h1,
    FSEL_ANY = 2'h2
  } alm_fsel_e;
endpackage

// >>> core/alm_matcher.sv
// layer-4 access control entry matcher with axi4-lite registers
// assumes frame headers parsed upstream, one cycle strobe per frame
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module alm_matcher (
  input wire logic clk, // core clock 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic frm_valid, // parsed frame header strobe
  input wire logic [2:0] frm_port, // ingress switch port
  input wire logic frm_is_l4, // frame carries tcp or udp
  input wire logic frm_is_tcp, // frame carries tcp
  input wire logic [15:0] frm_src_port, // tcp/udp source port
  input wire logic [15:0] frm_dst_port, // tcp/udp destination port
  input wire logic [4:0] frm_flags, // fin, syn, psh, ack, urg
  input wire logic [47:0] frm_src_mac, // source mac address
  input wire logic [31:0] frm_src_ip, // source ip address
  output logic res_valid, // decision valid pulse
  output logic res_hit, // frame hits the entry
  output logic res_admit // frame admitted by source binding
);
  logic [31:0] ctrl_reg;
  logic [31:0] src_lim_reg [2];
  logic [31:0] dst_lim_reg [2];
  logic [31:0] bind_en_reg;
  logic [31:0] mac_lo_reg;
  logic [31:0] mac_hi_reg;
  logic [31:0] ip_reg;
  logic [31:0] hit_cnt_reg;
  logic [31:0] drop_cnt_reg;
  logic [5:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic wr_fire;
  logic src_ok;
  logic dst_ok;
  logic [alm_pkg::NUM_FLAGS-1:0] flag_ok;
  logic hit;
  logic admit;
  logic [1:0] src_sel;
  logic [1:0] dst_sel;

  // axi write channels taken independently, in either order
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // address held until its data arrives; a pending response blocks the next write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  // data held on its own; the write fires once both halves are held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // byte-lane merge, so a partial write leaves the other lanes intact
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // holes and unaligned addresses refused; status and counters accept writes
  function automatic logic wr_ok(input logic [5:0] a);
    logic r;
    r = 1'b1;
    if (a == alm_pkg::OFF_STATUS || a == alm_pkg::OFF_HIT_CNT) begin
      r = 1'b1;
    end else if (a > alm_pkg::OFF_DROP_CNT || a[1:0] != 2'h0) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // response raised in the cycle after both halves are held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= alm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok(aw_addr_reg) ? alm_pkg::RESP_OKAY : alm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // entry configuration registers
  // unused high bits masked, so they read back as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= alm_pkg::CTRL_RESET;
      src_lim_reg[0] <= 32'h0000_0000;
      src_lim_reg[1] <= 32'h0000_0000;
      dst_lim_reg[0] <= 32'h0000_0000;
      dst_lim_reg[1] <= 32'h0000_0000;
      bind_en_reg <= 32'h0000_0000;
      mac_lo_reg <= 32'h0000_0000;
      mac_hi_reg <= 32'h0000_0000;
      ip_reg <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (aw_addr_reg == alm_pkg::OFF_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_3FFF;
      end else if (aw_addr_reg == alm_pkg::OFF_SRC_LO) begin
        src_lim_reg[0] <= merge(src_lim_reg[0], w_data_reg, w_strb_reg) & 32'h0000_FFFF;
      end else if (aw_addr_reg == alm_pkg::OFF_SRC_HI) begin
        src_lim_reg[1] <= merge(src_lim_reg[1], w_data_reg, w_strb_reg) & 32'h0000_FFFF;
      end else if (aw_addr_reg == alm_pkg::OFF_DST_LO) begin
        dst_lim_reg[0] <= merge(dst_lim_reg[0], w_data_reg, w_strb_reg) & 32'h0000_FFFF;
      end else if (aw_addr_reg == alm_pkg::OFF_DST_HI) begin
        dst_lim_reg[1] <= merge(dst_lim_reg[1], w_data_reg, w_strb_reg) & 32'h0000_FFFF;
      end else if (aw_addr_reg == alm_pkg::OFF_BIND_EN) begin
        bind_en_reg <= merge(bind_en_reg, w_data_reg, w_strb_reg) & 32'h0000_00FF;
      end else if (aw_addr_reg == alm_pkg::OFF_BIND_MAC_LO) begin
        mac_lo_reg <= merge(mac_lo_reg, w_data_reg, w_strb_reg);
      end else if (aw_addr_reg == alm_pkg::OFF_BIND_MAC_HI) begin
        mac_hi_reg <= merge(mac_hi_reg, w_data_reg, w_strb_reg) & 32'h0000_FFFF;
      end else if (aw_addr_reg == alm_pkg::OFF_BIND_IP) begin
        ip_reg <= merge(ip_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  // port conditions
  assign src_sel = ctrl_reg[alm_pkg::CTRL_SRC_SEL_LSB +: 2];
  assign dst_sel = ctrl_reg[alm_pkg::CTRL_DST_SEL_LSB +: 2];

  // non-l4 frames never satisfy a port value or range
  always_comb begin
    case (src_sel)
      alm_pkg::PSEL_ANY: src_ok = 1'b1; // [R1]
      alm_pkg::PSEL_SPECIFIC: src_ok = frm_is_l4 &&
                                       frm_src_port == src_lim_reg[0][15:0]; // [R2]
      alm_pkg::PSEL_RANGE: src_ok = frm_is_l4 && frm_src_port >= src_lim_reg[0][15:0] &&
                                     frm_src_port <= src_lim_reg[1][15:0]; // [R3]
      default: src_ok = 1'b0;
    endcase
  end

  // same decode for the destination port
  always_comb begin
    case (dst_sel)
      alm_pkg::PSEL_ANY: dst_ok = 1'b1; // [R4]
      alm_pkg::PSEL_SPECIFIC: dst_ok = frm_is_l4 &&
                                       frm_dst_port == dst_lim_reg[0][15:0]; // [R5]
      alm_pkg::PSEL_RANGE: dst_ok = frm_is_l4 && frm_dst_port >= dst_lim_reg[0][15:0] &&
                                     frm_dst_port <= dst_lim_reg[1][15:0]; // [R6]
      default: dst_ok = 1'b0;
    endcase
  end

  // flag conditions, one per tcp flag; non-tcp frames pass
  // selector 3 is reserved and never hits, whatever the frame
  generate
    for (genvar g = 0; g < alm_pkg::NUM_FLAGS; g++) begin : g_flag
      logic [1:0] fsel;
      assign fsel = ctrl_reg[alm_pkg::CTRL_FLAG_LSB + 2*g +: 2];
      always_comb begin
        case (fsel)
          alm_pkg::FSEL_ZERO: flag_ok[g] = !frm_is_tcp ||
                                           !frm_flags[g]; // [R7] [R8] [R9] [R10] [R11]
          alm_pkg::FSEL_ONE: flag_ok[g] = !frm_is_tcp ||
                                          frm_flags[g]; // [R7] [R8] [R9] [R10] [R11]
          alm_pkg::FSEL_ANY: flag_ok[g] = 1'b1; // [R12]
          default: flag_ok[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  assign hit = src_ok && dst_ok && (&flag_ok); // [R14]
  // ports without binding admit all; admit is kept apart from the hit
  assign admit = !bind_en_reg[frm_port] ||
                 (frm_src_mac == {mac_hi_reg[15:0], mac_lo_reg} &&
                  frm_src_ip == ip_reg); // [R13]

  // decision held until the next header, so status reads stay meaningful
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_hit <= 1'b0;
      res_admit <= 1'b0;
    end else begin
      res_valid <= frm_valid;
      if (frm_valid) begin
        res_hit <= hit;
        res_admit <= admit;
      end
    end
  end

  // hit counter cleared by writing its offset; a hit in that cycle still counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_cnt_reg <= 32'h0000_0000;
    end else if (frm_valid && hit) begin
      hit_cnt_reg <= (wr_fire && aw_addr_reg == alm_pkg::OFF_HIT_CNT) ? 32'h0000_0001 :
                     hit_cnt_reg + 32'h0000_0001;
    end else if (wr_fire && aw_addr_reg == alm_pkg::OFF_HIT_CNT) begin
      hit_cnt_reg <= 32'h0000_0000;
    end
  end

  // drop counter, same clear rule as the hit counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt_reg <= 32'h0000_0000;
    end else if (frm_valid && !admit) begin
      drop_cnt_reg <= (wr_fire && aw_addr_reg == alm_pkg::OFF_DROP_CNT) ? 32'h0000_0001 :
                      drop_cnt_reg + 32'h0000_0001;
    end else if (wr_fire && aw_addr_reg == alm_pkg::OFF_DROP_CNT) begin
      drop_cnt_reg <= 32'h0000_0000;
    end
  end

  // read path, one outstanding read
  // arready low while rvalid stands, so rdata cannot move under the master
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= alm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= alm_pkg::RESP_OKAY;
      if (s_axi_araddr == alm_pkg::OFF_CTRL) begin
        s_axi_rdata <= ctrl_reg;
      end else if (s_axi_araddr == alm_pkg::OFF_SRC_LO) begin
        s_axi_rdata <= src_lim_reg[0];
      end else if (s_axi_araddr == alm_pkg::OFF_SRC_HI) begin
        s_axi_rdata <= src_lim_reg[1];
      end else if (s_axi_araddr == alm_pkg::OFF_DST_LO) begin
        s_axi_rdata <= dst_lim_reg[0];
      end else if (s_axi_araddr == alm_pkg::OFF_DST_HI) begin
        s_axi_rdata <= dst_lim_reg[1];
      end else if (s_axi_araddr == alm_pkg::OFF_BIND_EN) begin
        s_axi_rdata <= bind_en_reg;
      end else if (s_axi_araddr == alm_pkg::OFF_BIND_MAC_LO) begin
        s_axi_rdata <= mac_lo_reg;
      end else if (s_axi_araddr == alm_pkg::OFF_BIND_MAC_HI) begin
        s_axi_rdata <= mac_hi_reg;
      end else if (s_axi_araddr == alm_pkg::OFF_BIND_IP) begin
        s_axi_rdata <= ip_reg;
      end else if (s_axi_araddr == alm_pkg::OFF_STATUS) begin
        s_axi_rdata <= {29'h0000_0000, res_admit, res_hit, res_valid};
      end else if (s_axi_araddr == alm_pkg::OFF_HIT_CNT) begin
        s_axi_rdata <= hit_cnt_reg;
      end else if (s_axi_araddr == alm_pkg::OFF_DROP_CNT) begin
        s_axi_rdata <= drop_cnt_reg;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= alm_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> sim/alm_matcher_properties.sv
// checker for the layer-4 entry matcher, bound to its top ports
// assumes full-word register writes; shadows the ctrl word from the axi traffic
`timescale 1ns/1ps
module alm_matcher_properties (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic frm_valid, // header strobe
  input wire logic frm_is_l4, // tcp or udp
  input wire logic frm_is_tcp, // tcp
  input wire logic [4:0] frm_flags, // tcp flags
  input wire logic res_valid, // decision pulse
  input wire logic res_hit, // entry hit
  input wire logic res_admit // binding admit
);
  logic [5:0] aw_a;
  logic [31:0] w_d;
  logic [31:0] ctrl_sh;
  logic [31:0] cfg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ctrl takes effect in the cycle its response is raised
  assign cfg = (s_axi_bvalid && s_axi_bresp == alm_pkg::RESP_OKAY && aw_a == alm_pkg::OFF_CTRL)
    ? (w_d & 32'h0000_3FFF) : ctrl_sh;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) aw_a <= 6'h00;
    else if (s_axi_awvalid && s_axi_awready) aw_a <= s_axi_awaddr;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) w_d <= 32'h0;
    else if (s_axi_wvalid && s_axi_wready) w_d <= s_axi_wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl_sh <= 32'h0;
    else ctrl_sh <= cfg;
  end
  a_res_pulse: assert property (frm_valid |=> res_valid)
    else $error("no decision one cycle after a header");
  a_res_cause: assert property (res_valid |-> $past(frm_valid))
    else $error("decision without a header");
  a_res_hold: assert property (!frm_valid |=> $stable(res_hit) && $stable(res_admit))
    else $error("decision changed without a header");
  a_all_any: assert property (frm_valid && cfg[13:0] == 14'h2AA0 |=> res_hit)
    else $error("miss with every field ignored");
  a_src_non_l4: assert property (frm_valid && !frm_is_l4 && cfg[1:0] == 2'h1 |=> !res_hit)
    else $error("non-l4 frame hit a specific source port");
  a_dst_non_l4: assert property (frm_valid && !frm_is_l4 && cfg[3:2] == 2'h2 |=> !res_hit)
    else $error("non-l4 frame hit a destination range");
  a_fin_clear: assert property (frm_valid && frm_is_tcp && frm_flags[0] && cfg[5:4] == 2'h0
    |=> !res_hit)
    else $error("fin set frame hit a fin clear entry");
  a_urg_set: assert property (frm_valid && frm_is_tcp && !frm_flags[4] && cfg[13:12] == 2'h1
    |=> !res_hit)
    else $error("urg clear frame hit an urg set entry");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h2C
    |=> s_axi_rvalid && s_axi_rresp == alm_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
endmodule

// >>> sim/alm_frame_src.sv
// ingress pipeline model: presents queued parsed headers, one per edge
// assumes the bench pushes packed headers into q; slow adds idle gaps
`timescale 1ns/1ps
module alm_frame_src (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic slow, // idle cycle after each header
  output logic frm_valid, // header strobe
  output logic [2:0] frm_port, // ingress port
  output logic frm_is_l4, // tcp or udp
  output logic frm_is_tcp, // tcp
  output logic [15:0] frm_src_port, // source port
  output logic [15:0] frm_dst_port, // destination port
  output logic [4:0] frm_flags, // tcp flags
  output logic [47:0] frm_src_mac, // source mac
  output logic [31:0] frm_src_ip // source ip
);
  logic [121:0] q [$];
  logic gap;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frm_valid <= 1'b0;
      gap <= 1'b0;
      {frm_port, frm_is_l4, frm_is_tcp, frm_src_port, frm_dst_port, frm_flags, frm_src_mac,
        frm_src_ip} <= 122'h0;
    end else if (q.size() > 0 && !gap) begin
      frm_valid <= 1'b1;
      gap <= slow;
      {frm_port, frm_is_l4, frm_is_tcp, frm_src_port, frm_dst_port, frm_flags, frm_src_mac,
        frm_src_ip} <= q.pop_front();
    end else begin
      // idle header lines toggle so stale fields never look valid
      frm_valid <= 1'b0;
      gap <= 1'b0;
      {frm_port, frm_is_l4, frm_is_tcp, frm_src_port, frm_dst_port, frm_flags, frm_src_mac,
        frm_src_ip} <= ~{frm_port, frm_is_l4, frm_is_tcp, frm_src_port, frm_dst_port, frm_flags,
        frm_src_mac, frm_src_ip};
    end
  end
endmodule

// >>> sim/tb.sv
// self-checking bench for the layer-4 entry matcher against a queue model
// assumes alm_frame_src feeds the header port; registers over axi4-lite
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, frm_src_ip;
  wire logic frm_valid, frm_is_l4, frm_is_tcp, res_valid, res_hit, res_admit;
  wire logic [2:0] frm_port;
  wire logic [15:0] frm_src_port, frm_dst_port;
  wire logic [4:0] frm_flags;
  wire logic [47:0] frm_src_mac;
  logic [31:0] m [12];
  logic [1:0] exq [$];
  logic [1:0] ex;
  int failures = 0, total_checks = 0, seed;
  localparam logic [31:0] MSK [12] = '{32'h3FFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'hFF, 32'hFFFF_FFFF, 32'hFFFF, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0};
  alm_matcher DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .frm_valid, .frm_port, .frm_is_l4, .frm_is_tcp, .frm_src_port, .frm_dst_port,
    .frm_flags, .frm_src_mac, .frm_src_ip, .res_valid, .res_hit, .res_admit);
  alm_frame_src src (.clk, .rst_n, .slow, .frm_valid, .frm_port, .frm_is_l4, .frm_is_tcp,
    .frm_src_port, .frm_dst_port, .frm_flags, .frm_src_mac, .frm_src_ip);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] er;
    bit ta, tw, bv;
    er = (a > 6'h2C || a[1:0] != 2'h0) ? 2'h2 : 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      if (bv) chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bv) begin
        if (er == 2'h0 && a[5:2] != 4'h9) m[a[5:2]] = a[5:3] == 3'h5 ? 32'h0 : d & MSK[a[5:2]];
        return;
      end
    end
    failures++;
    close_out();
  endtask
  task automatic rd(input logic [5:0] a);
    logic [1:0] er;
    logic [31:0] ed;
    bit ta, rv;
    er = a > 6'h2C ? 2'h2 : 2'h0;
    ed = er == 2'h0 ? m[a[5:2]] : 32'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      if (rv) chk(s_axi_rdata, ed, "read data");
      if (rv) chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rv) begin
        return;
      end
    end
    failures++;
    close_out();
  endtask
  function automatic logic [15:0] pv();
    logic [31:0] r;
    r = $urandom;
    return r[3:2] == 2'h0 ? 16'hFFFF : {14'h0, r[1:0]};
  endfunction
  function automatic logic pok(logic [1:0] s, logic l4, logic [15:0] p, logic [31:0] lo,
    logic [31:0] hi);
    case (s)
      2'h0: return 1'b1;
      2'h1: return l4 && p == lo[15:0];
      2'h2: return l4 && p >= lo[15:0] && p <= hi[15:0];
      default: return 1'b0;
    endcase
  endfunction
  task automatic frame();
    logic [31:0] r;
    logic [15:0] sp, dp;
    logic [47:0] mac;
    logic [31:0] ip;
    logic [1:0] s;
    logic hit, adm;
    r = $urandom;
    sp = pv();
    dp = pv();
    mac = r[10] ? {m[7][15:0], m[6]} : {r, r[15:0]};
    ip = r[11] ? m[8] : r;
    hit = pok(m[0][1:0], r[0] | r[1], sp, m[1], m[2]) &&
          pok(m[0][3:2], r[0] | r[1], dp, m[3], m[4]);
    for (int i = 0; i < 5; i++) begin
      s = m[0][4 + 2 * i +: 2];
      // selector 3 never hits; 0 and 1 judge tcp frames only; 2 ignores the flag
      if (s == 2'h3 ||
          (r[0] && s != 2'h2 && s[0] != r[2 + i])) hit = 1'b0;
    end
    adm = !m[5][r[9:7]] || (mac == {m[7][15:0], m[6]} && ip == m[8]);
    exq.push_back({hit, adm});
    m[9] = {29'h0, adm, hit, 1'b0};
    m[10] = m[10] + {31'h0, hit};
    m[11] = m[11] + {31'h0, !adm};
    src.q.push_back({r[9:7], r[0] | r[1], r[0], sp, dp, r[6:2], mac, ip});
  endtask
  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      if (exq.size() == 0) chk(32'h1, 32'h0, "decision without a header");
      else begin
        ex = exq.pop_front();
        chk({30'h0, res_hit, res_admit}, {30'h0, ex}, "frame decision");
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    failures++;
    close_out();
  end
  initial begin
    {rst_n, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    foreach (m[i]) m[i] = 32'h0;
    seed = $urandom(54);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 12; i++) rd(6'(i * 4));
    rd(6'h30);
    wr(6'h02, 32'hFFFF_FFFF);
    wr(6'h34, 32'h1);
    $display("test reset_map done");
    for (int c = 0; c < 40; c++) begin
      wr(6'h00, c == 0 ? 32'h2AA0 : (c % 3 == 0 ? (($urandom & 32'hC00F) | 32'h2AA0) : $urandom));
      for (int a = 1; a < 5; a++) wr(6'(a * 4), ($urandom & 32'hFFFF_0000) | {16'h0, pv()});
      for (int a = 5; a < 9; a++) wr(6'(a * 4), $urandom);
      slow <= c[0];
      repeat (12) frame();
      for (int n = 0; n < 100 && (src.q.size() > 0 || exq.size() > 0); n++) @(posedge clk);
      if (exq.size() > 0) chk(32'h1, 32'h0, "decisions missing");
    end
    $display("test random_frames done");
    wr(6'h24, 32'hFFFF_FFFF);
    for (int i = 0; i < 12; i++) rd(6'(i * 4));
    wr(6'h28, 32'h0);
    wr(6'h2C, 32'h0);
    rd(6'h28);
    rd(6'h2C);
    $display("test counters done");
    close_out();
  end
endmodule
bind alm_matcher alm_matcher_properties u_props (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .frm_valid,
  .frm_is_l4, .frm_is_tcp, .frm_flags, .res_valid, .res_hit, .res_admit);
